// ===== pkg/branch_cmp_ext_regs.vh
// register map, field positions and op codes of the branch, compare and extract unit
// assumes an apb slave with 32-bit data; every register is one aligned word
`ifndef BRANCH_CMP_EXT_REGS_VH
`define BRANCH_CMP_EXT_REGS_VH

// byte addresses
`define OFS_EXEC 8'h00
`define OFS_IMM 8'h04
`define OFS_OPA 8'h08
`define OFS_OPB 8'h0C
`define OFS_PREFIX_K 8'h10
`define OFS_PC 8'h14
`define OFS_RESULT 8'h20
`define OFS_LINK 8'h24
`define OFS_STATUS 8'h2C

// exec register fields
`define EXEC_OP_HI 3
`define EXEC_OP_LO 0
`define EXEC_PREFIXED 4
`define EXEC_NEXT_IS_PREFIX 5

// status register fields
`define ST_FLAGS_HI 3
`define ST_OPA_WRITTEN 4
`define ST_ZERO_WRITTEN 5
`define ST_LINK_WRITTEN 6
`define ST_DELAY_PENDING 7
`define ST_SKIPPED 8

// operation codes
`define OP_STEP 4'h0
`define OP_REL_BRANCH 4'h1
`define OP_REL_SUB_BRANCH 4'h2
`define OP_REG_SUB_BRANCH 4'h3
`define OP_REG_COMPARE 4'h4
`define OP_IMM_COMPARE 4'h5
`define OP_HW_EXTRACT_DYN 4'h6
`define OP_HW_EXTRACT_STAT 4'h7
`define OP_BYTE_EXTRACT_DYN 4'h8
`define OP_BYTE_EXTRACT_STAT 4'h9
`define OP_HW_REPLICATE 4'hA
`define OP_BYTE_REPLICATE 4'hB
`define OP_SKIP_ON_ONE 4'hC

// reset values and pc steps in bytes
`define RST_WORD 32'h00000000
`define PC_STEP_ONE 32'h00000002
`define PC_STEP_SKIP 32'h00000004
`define PC_STEP_SKIP_PREFIX 32'h00000006
`define LINK_AHEAD 32'h00000004

`endif

// ===== hdl/branch_cmp_ext.v
// execution unit for branches, compares, extracts, fills and bit skip
// assumes an apb master on ref_clk; operands are loaded by software before each exec write
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "branch_cmp_ext_regs.vh"

module branch_cmp_ext #(
   parameter ADDR_W = 8
) (
   input wire ref_clk, // 200 MHz clock
   input wire nrst, // asynchronous reset, active low
   input wire psel, // apb select
   input wire penable, // apb access phase
   input wire pwrite, // apb direction, high for write
   input wire [ADDR_W-1:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data, captured in the setup cycle
   output wire pready, // apb ready, always high
   output wire pslverr // apb error on unmapped address
);

   // software-loaded operands and instruction fields
   reg [31:0] opa_q;
   reg [31:0] opb_q;
   reg [10:0] imm_q;
   reg [10:0] prefix_k_q;
   // architectural state
   reg [31:0] pc_q;
   reg [31:0] pc_d;
   reg [31:0] target_q;
   reg [31:0] target_d;
   reg delay_q;
   reg delay_d;
   reg [31:0] result_q;
   reg [31:0] result_d;
   reg [31:0] link_q;
   reg [31:0] link_d;
   reg [3:0] flags_q; // {n, v, z, c}
   reg [3:0] flags_d;
   reg opa_wr_q;
   reg opa_wr_d;
   reg zero_wr_q;
   reg zero_wr_d;
   reg link_wr_q;
   reg link_wr_d;
   reg skipped_q;
   reg skipped_d;

   // bus decode
   wire access = psel & penable;
   wire wr_en = access & pwrite;
   reg addr_hit;
   wire exec_go = wr_en & (paddr == `OFS_EXEC);
   wire [3:0] op = pwdata[`EXEC_OP_HI:`EXEC_OP_LO];
   wire prefixed = pwdata[`EXEC_PREFIXED];
   wire next_is_prefix = pwdata[`EXEC_NEXT_IS_PREFIX];

   // zero wait states: every register is a flop, so the answer is ready at once
   assign pready = 1'b1;
   assign pslverr = access & ~addr_hit;

   // subtract datapath shared by both compares
   wire [31:0] sub_b;
   wire [32:0] sub_full;
   wire [31:0] sub_r;
   wire [31:0] imm_k_const;
   wire [31:0] imm_small;
   assign imm_k_const = {16'h0000, prefix_k_q, imm_q[4:0]};
   assign imm_small = {27'h0000000, imm_q[4:0]};
   assign sub_b = (op == `OP_REG_COMPARE) ? opb_q : (prefixed ? imm_k_const : imm_small);
   assign sub_full = {1'b0, opa_q} - {1'b0, sub_b};
   assign sub_r = sub_full[31:0];

   // branch offset in bytes: signed halfword count plus one, doubled
   wire [31:0] offs_sext;
   wire [31:0] rel_target;
   assign offs_sext = {{21{imm_q[10]}}, imm_q};
   assign rel_target = pc_q + ((offs_sext + 32'h00000001) << 1);

   // byte lanes for the two byte extracts, one mux each
   wire [7:0] byte_dyn;
   wire [7:0] byte_stat;
   byte_lane_pick #(.LANE_W(8)) i_pick_dyn (
      .word(opa_q), // source operand
      .sel(opb_q[1:0]), // lane from the second operand
      .lane(byte_dyn) // picked byte
   );
   byte_lane_pick #(.LANE_W(8)) i_pick_stat (
      .word(opa_q), // source operand
      .sel(imm_q[1:0]), // lane from the select field
      .lane(byte_stat) // picked byte
   );

   // address decode for the error answer
   always @* begin
      case (paddr)
         `OFS_EXEC, `OFS_IMM, `OFS_OPA, `OFS_OPB, `OFS_PREFIX_K, `OFS_PC,
         `OFS_RESULT, `OFS_LINK, `OFS_STATUS: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   end

   // execute one instruction on a write to the exec register
   always @* begin
      pc_d = pc_q;
      target_d = target_q;
      delay_d = delay_q;
      result_d = result_q;
      link_d = link_q;
      flags_d = flags_q;
      opa_wr_d = opa_wr_q;
      zero_wr_d = zero_wr_q;
      link_wr_d = link_wr_q;
      skipped_d = skipped_q;
      if (exec_go) begin
         opa_wr_d = 1'b0;
         zero_wr_d = 1'b0;
         link_wr_d = 1'b0;
         skipped_d = 1'b0;
         pc_d = pc_q + `PC_STEP_ONE;
         case (op)
            `OP_REL_BRANCH: begin
               target_d = rel_target;
            end
            `OP_REL_SUB_BRANCH: begin
               target_d = rel_target;
               link_d = (pc_q + `LINK_AHEAD) >> 1;
               link_wr_d = 1'b1;
            end
            `OP_REG_SUB_BRANCH: begin
               target_d = opa_q << 1;
               link_d = (pc_q + `LINK_AHEAD) >> 1;
               link_wr_d = 1'b1;
            end
            `OP_REG_COMPARE, `OP_IMM_COMPARE: begin
               // difference is dropped; only the flags change
               flags_d[3] = sub_r[31];
               flags_d[2] = (opa_q[31] ^ sub_b[31]) & (sub_r[31] ^ opa_q[31]);
               flags_d[1] = (sub_r == 32'h00000000);
               flags_d[0] = sub_full[32];
            end
            `OP_HW_EXTRACT_DYN: begin
               result_d = {16'h0000, opb_q[1] ? opa_q[31:16] : opa_q[15:0]};
               opa_wr_d = 1'b1;
            end
            `OP_HW_EXTRACT_STAT: begin
               result_d = {16'h0000, imm_q[0] ? opa_q[31:16] : opa_q[15:0]};
               opa_wr_d = 1'b1;
            end
            `OP_BYTE_EXTRACT_DYN: begin
               result_d = {24'h000000, byte_dyn};
               opa_wr_d = 1'b1;
            end
            `OP_BYTE_EXTRACT_STAT: begin
               result_d = {24'h000000, byte_stat};
               opa_wr_d = 1'b1;
            end
            `OP_HW_REPLICATE: begin
               // the register file is outside, so only the destination is flagged
               result_d = {opa_q[15:0], opa_q[15:0]};
               zero_wr_d = 1'b1;
            end
            `OP_BYTE_REPLICATE: begin
               result_d = {4{opa_q[7:0]}};
               zero_wr_d = 1'b1;
            end
            `OP_SKIP_ON_ONE: begin
               if (opa_q[imm_q[4:0]]) begin
                  // a prefix and its instruction are skipped as one unit
                  pc_d = next_is_prefix ? pc_q + `PC_STEP_SKIP_PREFIX : pc_q + `PC_STEP_SKIP;
                  skipped_d = 1'b1;
               end
            end
            default: begin
               // any other instruction just steps; it may be a delay slot
            end
         endcase
         // the instruction after a branch runs first, then the target is taken
         if (delay_q) begin
            pc_d = target_q;
            delay_d = 1'b0;
         end else if (op == `OP_REL_BRANCH || op == `OP_REL_SUB_BRANCH || op == `OP_REG_SUB_BRANCH) begin
            delay_d = 1'b1;
         end
      end else if (wr_en && paddr == `OFS_PC) begin
         // a software pc load abandons any pending branch
         pc_d = pwdata;
         delay_d = 1'b0;
      end
   end

   // state and operand registers
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         opa_q <= `RST_WORD;
         opb_q <= `RST_WORD;
         imm_q <= 11'h000;
         prefix_k_q <= 11'h000;
         pc_q <= `RST_WORD;
         target_q <= `RST_WORD;
         delay_q <= 1'b0;
         result_q <= `RST_WORD;
         link_q <= `RST_WORD;
         flags_q <= 4'h0;
         opa_wr_q <= 1'b0;
         zero_wr_q <= 1'b0;
         link_wr_q <= 1'b0;
         skipped_q <= 1'b0;
      end else begin
         if (wr_en && paddr == `OFS_OPA) begin
            opa_q <= pwdata;
         end
         if (wr_en && paddr == `OFS_OPB) begin
            opb_q <= pwdata;
         end
         if (wr_en && paddr == `OFS_IMM) begin
            imm_q <= pwdata[10:0];
         end
         if (wr_en && paddr == `OFS_PREFIX_K) begin
            prefix_k_q <= pwdata[10:0];
         end
         pc_q <= pc_d;
         target_q <= target_d;
         delay_q <= delay_d;
         result_q <= result_d;
         link_q <= link_d;
         flags_q <= flags_d;
         opa_wr_q <= opa_wr_d;
         zero_wr_q <= zero_wr_d;
         link_wr_q <= link_wr_d;
         skipped_q <= skipped_d;
      end
   end

   // read mux; every source is a flop, unmapped and exec reads give zero
   reg [31:0] rd_mux;
   always @* begin
      case (paddr)
         `OFS_IMM: rd_mux = {21'h00000, imm_q};
         `OFS_OPA: rd_mux = opa_q;
         `OFS_OPB: rd_mux = opb_q;
         `OFS_PREFIX_K: rd_mux = {21'h00000, prefix_k_q};
         `OFS_PC: rd_mux = pc_q;
         `OFS_RESULT: rd_mux = result_q;
         `OFS_LINK: rd_mux = link_q;
         `OFS_STATUS: rd_mux = {23'h00000, skipped_q, delay_q, link_wr_q, zero_wr_q, opa_wr_q, flags_q};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // read data captured in the setup cycle so prdata comes from a flop
   // no write can land between setup and access of one read, so it stays current
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= `RST_WORD;
      end else if (psel && !penable) begin
         prdata <= rd_mux;
      end
   end

endmodule

// one lane out of a four-lane word, lane 3 the most significant
// kept as its own block so both byte extracts share one mux shape
module byte_lane_pick #(
   parameter LANE_W = 8
) (
   input wire [4*LANE_W-1:0] word, // word to pick from
   input wire [1:0] sel, // lane index
   output reg [LANE_W-1:0] lane // picked lane
);

   // plain four-way mux; lane 0 sits in the low bits
   always @* begin
      case (sel)
         2'b00: lane = word[LANE_W-1:0];
         2'b01: lane = word[2*LANE_W-1:LANE_W];
         2'b10: lane = word[3*LANE_W-1:2*LANE_W];
         default: lane = word[4*LANE_W-1:3*LANE_W];
      endcase
   end

endmodule

// ===== tb/branch_cmp_ext_sva.sv
// assertions on the apb ports of the branch, compare and extract unit
// assumes the register map and op codes of branch_cmp_ext
`timescale 1ns/1ps
module branch_cmp_ext_sva #(
   parameter ADDR_W = 8
) (
   input wire ref_clk, // clock
   input wire nrst, // reset, active low
   input wire psel, // select
   input wire penable, // access phase
   input wire pwrite, // direction
   input wire [ADDR_W-1:0] paddr, // address
   input wire [31:0] pwdata, // write data
   input wire [31:0] prdata, // read data
   input wire pready, // ready
   input wire pslverr // error
);
   reg [3:0] op_q;
   wire acc = psel && penable;
   wire rd_res = acc && !pwrite && paddr == 8'h20;
   wire mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h24, 8'h2C};
   // last executed op, so result reads can be judged by kind
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) op_q <= 4'h0;
      else if (acc && pwrite && paddr == 8'h00) op_q <= pwdata[3:0];
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   AST_READY: assert property (psel |-> pready) else $error("ready low");
   AST_ERR_UNMAPPED: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   AST_NO_ERR: assert property (acc && mapped |-> !pslverr) else $error("error on mapped address");
   AST_EXEC_RD: assert property (acc && !pwrite && paddr == 8'h00 |-> prdata == 32'h0) else $error("exec reads nonzero");
   AST_HW_ZERO: assert property (rd_res && op_q inside {4'h6, 4'h7} |-> prdata[31:16] == 16'h0)
      else $error("halfword upper bits set");
   AST_BYTE_ZERO: assert property (rd_res && op_q inside {4'h8, 4'h9} |-> prdata[31:8] == 24'h0)
      else $error("byte upper bits set");
   AST_HALFWORD_REPLICATE: assert property (rd_res && op_q == 4'hA |-> prdata[31:16] == prdata[15:0])
      else $error("halfword fill halves differ");
   AST_BYTE_REPLICATE: assert property (rd_res && op_q == 4'hB |-> prdata == {4{prdata[7:0]}})
      else $error("byte fill bytes differ");
endmodule
bind branch_cmp_ext branch_cmp_ext_sva #(.ADDR_W(ADDR_W)) i_sva (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr));

// ===== tb/tb_soft_cpu_branch_compare_extract_ops.sv
// self-checking bench: random ops against a behavioural model
// assumes branch_cmp_ext with zero-wait apb and the checker bound
`timescale 1ns/1ps
module tb_soft_cpu_branch_compare_extract_ops;
   logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, pend, err, pf, np;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, a, b, bb, d, res, tgt, nt, lk, pc_m;
   logic [10:0] imm, k;
   logic [3:0] fl, op;
   int num_errors, n_tests, step;
   branch_cmp_ext #(.ADDR_W(8)) i_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // 200 MHz clock
   initial begin
      ref_clk = 0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one apb transfer; request held until pready seen high
   task automatic apb(logic w, logic [7:0] ad, logic [31:0] dt);
      @(posedge ref_clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= dt;
      @(posedge ref_clk);
      penable <= 1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wrap_up;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // hang guard, well above the expected run
   initial begin
      repeat (60000) @(posedge ref_clk);
      num_errors++;
      wrap_up;
   end
   // main sequence
   initial begin
      psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; nrst = 0;
      fl = 0; pend = 0; pc_m = 0; tgt = 0;
      void'($urandom(32'hFF68));
      repeat (16) @(posedge ref_clk);
      nrst <= 1;
      apb(0, 8'h14, 0); chk("pc reset", rd, 0);
      apb(0, 8'h2C, 0); chk("status reset", rd, 0);
      apb(1, 8'h30, 32'hFFFFFFFF); chk("slverr wr", err, 1);
      apb(0, 8'h30, 0); chk("slverr rd", err, 1);
      chk("unmapped rd data", rd, 0);
      apb(0, 8'h00, 0); chk("exec rd", rd, 0);
      for (int i = 0; i < 300; i++) begin
         a = (i % 4 == 0) ? 32'h80000000 : $urandom;
         b = (i % 5 == 0) ? a : $urandom;
         imm = $urandom; k = $urandom; pf = $urandom; np = $urandom;
         op = $urandom_range(12);
         if (pend && op inside {1, 2, 3}) op = 0;
         // pc write drops a pending target
         if (i % 50 == 7) begin
            pc_m = $urandom & 32'hFFFFFFFE;
            pend = 0;
            apb(1, 8'h14, pc_m);
         end
         apb(1, 8'h08, a); apb(1, 8'h0C, b); apb(1, 8'h04, {21'h0, imm}); apb(1, 8'h10, {21'h0, k});
         apb(1, 8'h00, {26'h0, np, pf, op});
         step = 2;
         res = 0;
         case (op)
            4, 5: begin
               bb = op == 4 ? b : pf ? {16'h0, k, imm[4:0]} : {27'h0, imm[4:0]};
               d = a - bb;
               fl = {d[31], a[31] != bb[31] && d[31] != a[31], d == 0, a < bb};
            end
            6: res = b[1] ? a[31:16] : a[15:0];
            7: res = imm[0] ? a[31:16] : a[15:0];
            8: res = (a >> (8 * b[1:0])) & 32'hFF;
            9: res = (a >> (8 * imm[1:0])) & 32'hFF;
            10: res = {2{a[15:0]}};
            11: res = {4{a[7:0]}};
            12: if (a[imm[4:0]]) step = np ? 6 : 4;
            default: ;
         endcase
         nt = op == 3 ? a << 1 : pc_m + (({{21{imm[10]}}, imm} + 1) << 1);
         lk = (pc_m + 4) >> 1;
         if (pend) begin
            pc_m = tgt;
            pend = 0;
         end else pc_m += step;
         if (op inside {1, 2, 3}) begin
            pend = 1;
            tgt = nt;
         end
         apb(0, 8'h14, 0); chk("pc", rd, pc_m);
         apb(0, 8'h2C, 0); chk("flags", rd[3:0], fl);
         chk("pending", rd[7], pend);
         chk("writes", rd[6:4], {op inside {2, 3}, op inside {10, 11}, op inside {[6:9]}});
         if (op == 12) chk("skipped", rd[8], step != 2);
         if (op inside {[6:11]}) begin
            chk("dest", rd[5:4], op > 9 ? 2'b10 : 2'b01);
            apb(0, 8'h20, 0); chk("result", rd, res);
         end
         if (op inside {2, 3}) begin
            apb(0, 8'h24, 0); chk("link", rd, lk);
         end
         if (op == 4) begin
            apb(0, 8'h0C, 0); chk("operand kept", rd, b);
         end
      end
      wrap_up;
   end
endmodule
